// *** agp1_pkg.sv ***
package agp1_pkg;
  // Register byte addresses, lower 20 bits of the advanced-mode address
  localparam logic [19:0] ADDR_DIR      = 20'hee000;
  localparam logic [19:0] ADDR_OUT      = 20'hfffd0;
  localparam int          ADDR_W        = 20;
  localparam int          PORT_W        = 8;
  // Reset values, and the value a direction read returns
  localparam logic [7:0]  DIR_RST_EXP   = 8'hff;
  localparam logic [7:0]  DIR_RST_OTHER = 8'h00;
  localparam logic [7:0]  OUT_RST       = 8'h00;
  localparam logic [7:0]  DIR_READ_VAL  = 8'hff;
  // Operating mode codes
  localparam logic [2:0]  MODE_EXP_LO   = 3'h1;
  localparam logic [2:0]  MODE_EXP_HI   = 3'h4;
  localparam logic [2:0]  MODE_EXP_ROM  = 3'h5;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // Pin function codes
  typedef enum logic [1:0] {
    AGP1_FN_INPUT,
    AGP1_FN_ADDR,
    AGP1_FN_DATA
  } agp1_fn_e;
endpackage

// *** agp1_sync.sv ***
`timescale 1ns/1ps
module agp1_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end
    else
    begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule

// *** agp1_pin_mux.sv ***
`timescale 1ns/1ps
module agp1_pin_mux #(
  parameter int WIDTH = 8
) (
  // Mode and selection
  input  wire logic             exp_mode,
  input  wire logic             rom_exp_mode,
  input  wire logic [WIDTH-1:0] dir_bits,
  // Output sources
  input  wire logic [WIDTH-1:0] addr_bits,
  input  wire logic [WIDTH-1:0] data_bits,
  // Pin drive
  output logic      [WIDTH-1:0] pin_val,
  output logic      [WIDTH-1:0] pin_oe
);
  // ----------------------------------------------------------------
  // Per-pin function
  // ----------------------------------------------------------------
  function automatic agp1_pkg::agp1_fn_e pin_fn(input logic expm,
                                              input logic romm,
                                              input logic dir);
    if (expm)
      pin_fn = agp1_pkg::AGP1_FN_ADDR;
    else if (romm)
      pin_fn = dir ? agp1_pkg::AGP1_FN_ADDR
                   : agp1_pkg::AGP1_FN_INPUT;
    else
      pin_fn = dir ? agp1_pkg::AGP1_FN_DATA
                   : agp1_pkg::AGP1_FN_INPUT;
  endfunction

  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      case (pin_fn(exp_mode, rom_exp_mode, dir_bits[i]))
        agp1_pkg::AGP1_FN_ADDR:
        begin
          pin_oe[i]  = 1'b1;
          pin_val[i] = addr_bits[i];
        end
        agp1_pkg::AGP1_FN_DATA:
        begin
          pin_oe[i]  = 1'b1;
          pin_val[i] = data_bits[i];
        end
        default:
        begin
          pin_oe[i]  = 1'b0;
          pin_val[i] = 1'b0;
        end
      endcase
    end
  end
endmodule

// *** agp1_port.sv ***
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module agp1_port #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Chip state
  input  wire logic [2:0]       op_mode,
  input  wire logic             hw_standby,
  input  wire logic             sw_standby,
  // Address from the bus controller or DRAM multiplexer
  input  wire logic [WIDTH-1:0] bus_addr,
  // Pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  // AXI4-Lite write address
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic [2:0]       s_axi_awprot,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic [2:0]       s_axi_arprot,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic             exp_mode;
  logic             rom_exp_mode;
  logic             mode_in_range;
  logic             rst_or_hws_n;

  assign exp_mode     = (op_mode >= agp1_pkg::MODE_EXP_LO) &&
                        (op_mode <= agp1_pkg::MODE_EXP_HI);
  assign rom_exp_mode = (op_mode == agp1_pkg::MODE_EXP_ROM);
  assign mode_in_range = (op_mode != 3'h0);
  // Hardware standby acts as an extra reset term
  // Software standby needs no term: both registers simply hold
  assign rst_or_hws_n = nrst & ~hw_standby;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] dir_ff;
  logic [WIDTH-1:0] nxt_dir;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;
  logic             dir_init_ff;
  logic [WIDTH-1:0] pin_sync;
  logic [WIDTH-1:0] eff_dir;
  logic [WIDTH-1:0] pin_val;
  logic [WIDTH-1:0] pin_en;
  logic [WIDTH-1:0] pin_out_ff;
  logic [WIDTH-1:0] pin_oe_ff;

  // ----------------------------------------------------------------
  // AXI4-Lite slave state
  // ----------------------------------------------------------------
  logic             aw_held_ff;
  logic [19:0]      aw_addr_ff;
  logic             w_held_ff;
  logic [7:0]       w_data_ff;
  logic             w_lane0_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;

  logic             aw_take;
  logic             w_take;
  logic             wr_fire;
  logic             ar_take;
  logic             wr_dir_hit;
  logic             wr_out_hit;
  logic             rd_dir_hit;
  logic             rd_out_hit;
  logic [19:0]      rd_addr;
  logic [WIDTH-1:0] out_readback;
  logic [31:0]      rd_word;

  // Address compare on bits 19 to 2 of the low 20 bits only
  function automatic logic addr_hit(input logic [19:0] a,
                                    input logic [19:0] reg_addr);
    addr_hit = (a[19:2] == reg_addr[19:2]);
  endfunction

  // Set wins over clear when both land in one cycle
  function automatic logic flag_next(input logic set,
                                     input logic clr,
                                     input logic cur);
    flag_next = set ? 1'b1 : (clr ? 1'b0 : cur);
  endfunction

  assign aw_take = s_axi_awvalid & ~aw_held_ff & ~bvalid_ff;
  assign w_take  = s_axi_wvalid & ~w_held_ff & ~bvalid_ff;
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign ar_take = s_axi_arvalid & ~rvalid_ff;

  assign wr_dir_hit = addr_hit(aw_addr_ff, agp1_pkg::ADDR_DIR);
  assign wr_out_hit = addr_hit(aw_addr_ff, agp1_pkg::ADDR_OUT);
  assign rd_addr    = s_axi_araddr[agp1_pkg::ADDR_W-1:0];
  assign rd_dir_hit = addr_hit(rd_addr, agp1_pkg::ADDR_DIR);
  assign rd_out_hit = addr_hit(rd_addr, agp1_pkg::ADDR_OUT);

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  // Direction forced to ones in modes 1 to 4, so writes never land
  assign nxt_dir = exp_mode ? agp1_pkg::DIR_RST_EXP :
                   (wr_fire && wr_dir_hit && w_lane0_ff) ?
                   w_data_ff : dir_ff;
  assign nxt_out = (wr_fire && wr_out_hit && w_lane0_ff) ?
                   w_data_ff : out_ff;

  // Strap-dependent reset value is taken on the first clock after release
  always_ff @(posedge clock or negedge rst_or_hws_n)
  begin
    if (!rst_or_hws_n)
      dir_init_ff <= 1'b0;
    else
      dir_init_ff <= 1'b1;
  end

  // Sleep or software standby leaves these untouched (no clear term)
  always_ff @(posedge clock or negedge rst_or_hws_n)
  begin
    if (!rst_or_hws_n)
    begin
      dir_ff <= agp1_pkg::DIR_RST_OTHER;
      out_ff <= agp1_pkg::OUT_RST;
    end
    else
    begin
      dir_ff <= dir_init_ff ? nxt_dir :
                (exp_mode ? agp1_pkg::DIR_RST_EXP
                          : agp1_pkg::DIR_RST_OTHER);
      out_ff <= nxt_out;
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser and pin drive
  // ----------------------------------------------------------------
  // Kept on nrst alone so pin levels survive hardware standby
  agp1_sync #(
    .WIDTH    (WIDTH)
  ) u_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  assign eff_dir = exp_mode ? agp1_pkg::DIR_RST_EXP : dir_ff;

  agp1_pin_mux #(
    .WIDTH        (WIDTH)
  ) u_mux (
    .exp_mode     (exp_mode),
    .rom_exp_mode (rom_exp_mode),
    .dir_bits     (eff_dir),
    .addr_bits    (bus_addr),
    .data_bits    (out_ff),
    .pin_val      (pin_val),
    .pin_oe       (pin_en)
  );

  // Mode 0 is not a legal mode: keep the pins released
  always_ff @(posedge clock or negedge rst_or_hws_n)
  begin
    if (!rst_or_hws_n)
    begin
      pin_out_ff <= '0;
      pin_oe_ff  <= '0;
    end
    else
    begin
      pin_out_ff <= pin_val;
      pin_oe_ff  <= mode_in_range ? pin_en : '0;
    end
  end

  assign pin_out = pin_out_ff;
  assign pin_oe  = pin_oe_ff;

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  // Pin level for inputs, stored bit for outputs
  // Input bits lag the pins by the two synchroniser stages
  assign out_readback = (eff_dir & out_ff) | (~eff_dir & pin_sync);
  assign rd_word = rd_dir_hit ?
                   {24'h000000, agp1_pkg::DIR_READ_VAL} :
                   rd_out_hit ? {24'h000000, out_readback} :
                   32'h00000000;

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 20'h00000;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr[agp1_pkg::ADDR_W-1:0];
      end
      else if (wr_fire)
        aw_held_ff <= 1'b0;
      if (w_take)
      begin
        w_held_ff  <= 1'b1;
        w_data_ff  <= s_axi_wdata[7:0];
        w_lane0_ff <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= agp1_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_dir_hit || wr_out_hit) ? agp1_pkg::RESP_OKAY
                                              : agp1_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= agp1_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= (rd_dir_hit || rd_out_hit) ? agp1_pkg::RESP_OKAY
                                              : agp1_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Registered ready flags
  // ----------------------------------------------------------------
  // Built from the next state of the held flags, so the outputs come
  // from flops yet always match what the take terms accept
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  logic nxt_aw_held;
  logic nxt_w_held;
  logic nxt_bvalid;
  logic nxt_rvalid;

  assign nxt_aw_held = flag_next(aw_take, wr_fire, aw_held_ff);
  assign nxt_w_held  = flag_next(w_take, wr_fire, w_held_ff);
  assign nxt_bvalid  = flag_next(wr_fire, s_axi_bready, bvalid_ff);
  assign nxt_rvalid  = flag_next(ar_take, s_axi_rready, rvalid_ff);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      arready_ff <= 1'b1;
    end
    else
    begin
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
endmodule

// *** agp1_port_assertions.sv ***
`timescale 1ns/1ps
module agp1_port_chk #(
  parameter int WIDTH = 8
) (
  // Clock, reset and chip state
  input wire logic             clock,
  input wire logic             nrst,
  input wire logic [2:0]       op_mode,
  input wire logic             hw_standby,
  // Address and pins
  input wire logic [WIDTH-1:0] bus_addr,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe,
  // Register bus
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [31:0]      s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready
);
  // ----------------------------------------------------------
  // Decodes and properties
  // ----------------------------------------------------------
  wire logic exp_m;
  wire logic rom_m;
  wire logic ar_hit;
  wire logic dir_a;
  wire logic out_a;
  assign exp_m  = op_mode >= agp1_pkg::MODE_EXP_LO
               && op_mode <= agp1_pkg::MODE_EXP_HI;
  assign rom_m  = op_mode == agp1_pkg::MODE_EXP_ROM;
  assign ar_hit = s_axi_arvalid && s_axi_arready;
  assign dir_a  = s_axi_araddr[19:2] == agp1_pkg::ADDR_DIR[19:2];
  assign out_a  = s_axi_araddr[19:2] == agp1_pkg::ADDR_OUT[19:2];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Three settled cycles keep the check clear of reset release
  a_exp_all_oe: assert property ((exp_m && !hw_standby) [*3] |=>
    pin_oe == {WIDTH{1'b1}}) else $error("expanded mode pin not driven");
  a_exp_addr_out: assert property ((exp_m && !hw_standby) [*3] |=>
    pin_out == $past(bus_addr)) else $error("address not on pins");
  a_rom_addr_out: assert property ((rom_m && !hw_standby) [*3] |=>
    ((pin_out ^ $past(bus_addr)) & pin_oe) == {WIDTH{1'b0}})
    else $error("mode 5 output pin not address");
  a_hw_stby_pins: assert property (hw_standby [*2] |->
    pin_oe == {WIDTH{1'b0}} && pin_out == {WIDTH{1'b0}})
    else $error("pins driven in hardware standby");
  a_dir_reads_ones: assert property (ar_hit && dir_a |=>
    s_axi_rdata == {24'h000000, agp1_pkg::DIR_READ_VAL}
    && s_axi_rresp == agp1_pkg::RESP_OKAY) else $error("direction read");
  a_unmapped_err: assert property (ar_hit && !dir_a && !out_a |=>
    s_axi_rresp == agp1_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  a_read_answer: assert property (ar_hit |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("rvalid dropped");

  c_data_read: cover property (ar_hit && out_a);
  c_write: cover property (s_axi_awvalid && s_axi_awready);
  c_hw_stby: cover property (hw_standby [*2]);
endmodule

bind agp1_port agp1_port_chk #(.WIDTH(WIDTH)) u_agp1_port_chk (
  .clock(clock), .nrst(nrst), .op_mode(op_mode), .hw_standby(hw_standby),
  .bus_addr(bus_addr), .pin_out(pin_out), .pin_oe(pin_oe),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** agp1_pins.sv ***
`timescale 1ns/1ps
module agp1_pins (
  // Port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Board side
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  // ----------------------------------------------------------
  // Wire level
  // ----------------------------------------------------------
  // Driven pins read back their own level, released ones the board
  assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  logic        clock, nrst, hw_standby, sw_standby;
  logic [2:0]  op_mode;
  logic [7:0]  bus_addr, ext_val, pin_in, pin_out, pin_oe, ex;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          n_fail, samples_checked, cyc;
  localparam logic [31:0] A_DIR = {12'h000, agp1_pkg::ADDR_DIR};
  localparam logic [31:0] A_OUT = {12'h000, agp1_pkg::ADDR_OUT};

  agp1_port u_agp1_port (.clock(clock), .nrst(nrst), .op_mode(op_mode),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .bus_addr(bus_addr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  agp1_pins u_agp1_pins (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .pin_in(pin_in));

  // ----------------------------------------------------------
  // Clock, address stream and hang guard
  // ----------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Address changes every cycle, as it would with row/column output
  always @(posedge clock)
  begin
    bus_addr <= bus_addr + 8'h01;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      results();
    end
  end

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task results;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk_data(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_resp(input logic [1:0] g, input logic [1:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task axi_wr(input logic [31:0] a, input logic [7:0] d,
              input logic [3:0] s, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [31:0] a, output logic [31:0] d,
              output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task settle;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask
  // Mode is static, so each mode gets its own reset
  task mode_test(input logic [2:0] m);
    logic [7:0] de;
    @(posedge clock);
    nrst <= 1'b0;
    op_mode <= m;
    ext_val <= 8'h96 ^ {5'h00, m};
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    de = (m <= 3'h4) ? 8'hff : 8'h00;
    axi_rd(A_DIR, rd, rs);
    chk_data(rd, 32'h000000ff);
    axi_rd(A_OUT, rd, rs);
    chk_data(rd, {24'h000000, ext_val & ~de});
    @(negedge clock);
    chk_data({24'h000000, pin_oe}, {24'h000000, de});
    axi_wr(A_DIR, 8'h3c, 4'h1, rs);
    chk_resp(rs, agp1_pkg::RESP_OKAY);
    axi_wr(A_OUT, 8'hc3, 4'h1, rs);
    axi_wr(A_OUT, 8'h00, 4'h0, rs);
    chk_resp(rs, agp1_pkg::RESP_OKAY);
    de = (m <= 3'h4) ? 8'hff : 8'h3c;
    settle();
    chk_data({24'h000000, pin_oe}, {24'h000000, de});
    ex = (m <= 3'h5) ? bus_addr - 8'h01 : 8'hc3;
    chk_data({24'h0, pin_out & de}, {24'h0, ex & de});
    axi_rd(A_OUT, rd, rs);
    chk_data(rd, {24'h0, (8'hc3 & de) | (ext_val & ~de)});
    $display("test mode %0d done", m);
  endtask

  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial
  begin
    {nrst, hw_standby, sw_standby, op_mode, bus_addr, ext_val} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, n_fail, samples_checked, cyc} = '0;
    for (int m = 1; m <= 7; m++)
      mode_test(m[2:0]);
    ex = 8'h00 | (ext_val & 8'hc3);
    axi_rd({12'hfff, agp1_pkg::ADDR_OUT}, rd, rs);
    chk_data(rd, {24'h000000, ex});
    axi_rd(32'h00000100, rd, rs);
    chk_data(rd, 32'h00000000);
    chk_resp(rs, agp1_pkg::RESP_SLVERR);
    axi_wr(32'h00000104, 8'h55, 4'h1, rs);
    chk_resp(rs, agp1_pkg::RESP_SLVERR);
    $display("test bus errors done");
    axi_wr(A_OUT, 8'h24, 4'h1, rs);
    chk_resp(rs, agp1_pkg::RESP_OKAY);
    @(posedge clock);
    sw_standby <= 1'b1;
    settle();
    chk_data({24'h000000, pin_oe}, 32'h0000003c);
    chk_data({24'h000000, pin_out & 8'h3c}, 32'h00000024);
    @(posedge clock);
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    settle();
    chk_data({24'h000000, pin_oe}, 32'h00000000);
    @(posedge clock);
    hw_standby <= 1'b0;
    settle();
    axi_rd(A_OUT, rd, rs);
    chk_data(rd, {24'h000000, ext_val});
    axi_wr(A_DIR, 8'hff, 4'h1, rs);
    axi_rd(A_OUT, rd, rs);
    chk_data(rd, 32'h00000000);
    $display("test standby done");
    // Mode 0 is illegal and must keep every pin released
    @(posedge clock);
    nrst <= 1'b0;
    op_mode <= 3'h0;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    axi_wr(A_DIR, 8'hff, 4'h1, rs);
    settle();
    chk_data({24'h000000, pin_oe}, 32'h00000000);
    $display("test mode 0 done");
    results();
  end
endmodule
